// ---- common/rpd_pkg.sv ----
package rpd_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STACK_POINTER = 8'h04;
    localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h08;
    localparam logic [7:0] ADDR_PORT_LATCH = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_GENERAL_REG = 8'h14;

    // Field positions in the power control register.
    localparam int IDLE_BIT = 0;
    localparam int POWER_DOWN_BIT = 1;

    // Field positions in the status register.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_RESET_BIT = 2;
    localparam int STAT_OSC_BIT = 3;
    localparam int STAT_CORE_CLK_BIT = 4;

    // Values applied on reset.
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] REG_CLEAR = 8'h00;
    localparam logic [31:0] PORT_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Timing: oscillator periods per machine cycle, machine cycles for reset.
    localparam int MC_CLOCKS = 12;
    localparam logic [1:0] RESET_MC = 2'h2;
    localparam logic [1:0] MC_ZERO = 2'h0;
    localparam logic [1:0] MC_ONE = 2'h1;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_POWER_DOWN = 2'b10,
        MODE_RESET = 2'b11
    } mode_t;

    typedef struct packed {
        logic [3:0] count;
        logic tick;
    } mc_state_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        mode_t mode;
        logic [1:0] mc_count;
        logic core_reset;
        logic osc_run;
        logic core_clk_en;
        logic [7:0] power_control_reg;
        logic [7:0] stack_pointer_reg;
        logic [7:0] serial_buffer_reg;
        logic [31:0] port_latch;
        logic [7:0] general_reg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rpd_state_t;

endpackage : rpd_pkg

// ---- tb/reset_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module reset_source (
    input wire logic clock, // Clock.
    input wire logic start, // Load a pulse.
    input wire logic [7:0] len, // Pulse cycles.
    output logic reset_pin // Reset pin.
);
    logic [7:0] left_r = 8'h00;
    always @(posedge clock) begin
        left_r <= start ? len : left_r - {7'h0, left_r != 8'h00};
    end
    assign reset_pin = left_r != 8'h00;
endmodule : reset_source
`default_nettype wire

// ---- tb/rpd_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module rpd_monitor
    import rpd_pkg::*;
#(
    parameter int MACHINE_CLOCKS = MC_CLOCKS
) (
    input wire logic clock, // Clock.
    input wire logic rstn, // Reset.
    input wire logic reset_pin, // Pin.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Write.
    input wire logic [7:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic osc_run, // Oscillator.
    input wire logic core_clk_en, // Core clock.
    input wire logic core_reset, // Core reset.
    input wire logic [31:0] port_latch, // Ports.
    input wire logic [7:0] stack_pointer // Stack.
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic pc_wr;
    assign pc_wr = psel && penable && pready && pwrite && core_clk_en
        && paddr == ADDR_POWER_CONTROL;
    chk_zero_wait: assert property (psel && !penable |=> pready) else $error("late");
    chk_err_unmapped: assert property (psel && !penable && paddr > ADDR_GENERAL_REG
        |=> pslverr) else $error("no error");
    chk_power_down_entry: assert property (pc_wr && pwdata[POWER_DOWN_BIT]
        |=> !osc_run && !core_clk_en) else $error("no power-down");
    chk_osc_gates: assert property (!osc_run |-> !core_clk_en) else $error("core on");
    chk_power_down_hold: assert property (!osc_run && !$past(reset_pin, 2)
        |=> !osc_run) else $error("woke");
    chk_state_kept: assert property (!osc_run |=> $stable(port_latch)
        && $stable(stack_pointer)) else $error("state lost");
    chk_reset_vals: assert property (core_reset && $past(core_reset)
        |-> port_latch == PORT_RESET && stack_pointer == STACK_RESET) else $error("reset value");
    chk_reset_len: assert property ($rose(core_reset)
        |-> $past(reset_pin, 2 * MACHINE_CLOCKS)) else $error("early reset");
    chk_idle_entry: assert property (pc_wr && pwdata[IDLE_BIT] && !pwdata[POWER_DOWN_BIT]
        |=> !core_clk_en && osc_run) else $error("no idle");
endmodule : rpd_monitor
bind reset_and_power_down_control rpd_monitor #(.MACHINE_CLOCKS(MACHINE_CLOCKS)) i_rpd_monitor (
    .clock, .rstn, .reset_pin, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .osc_run, .core_clk_en, .core_reset, .port_latch, .stack_pointer);
`default_nettype wire

// ---- tb/test_reset_and_power_down_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_reset_and_power_down_control;
    import rpd_pkg::*;
    logic clock = '0, rstn = '0, irq_req = '0, psel = '0, penable = '0, pwrite = '0, start = '0;
    logic [7:0] paddr = '0, len = '0, stack_pointer;
    logic [31:0] pwdata = '0, prdata, port_latch, r1, r2;
    logic pready, pslverr, osc_run, core_clk_en, core_reset, reset_pin, seen;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int errors = 0, n_tests = 0, cycles = 0;
    reset_and_power_down_control #(.MACHINE_CLOCKS(3)) i_reset_and_power_down_control (
        .clock(clock),
        .rstn(rstn),
        .reset_pin(reset_pin),
        .irq_req(irq_req),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_run(osc_run),
        .core_clk_en(core_clk_en),
        .core_reset(core_reset),
        .port_latch(port_latch),
        .stack_pointer(stack_pointer)
    );
    reset_source i_reset_source (
        .clock(clock),
        .start(start),
        .len(len),
        .reset_pin(reset_pin)
    );
    initial forever #25 clock = ~clock;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("FAIL %s exp %h got %h", s, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, '0);
    endtask : rd
    task automatic gap(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : gap
    task automatic pulse(input logic [7:0] n);
        start <= 1'b1;
        len <= n;
        @(posedge clock);
        start <= 1'b0;
        seen = 1'b0;
        repeat (40) begin
            @(posedge clock);
            if (core_reset === 1'b1) seen = 1'b1;
        end
    endtask : pulse
    always @(posedge clock) begin
        cycles++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            chk("prdata", e[31:0], prdata);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'ha2c1));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("port_latch", PORT_RESET, port_latch);
        chk("stack_pointer", {24'h0, STACK_RESET}, {24'h0, stack_pointer});
        rd(ADDR_GENERAL_REG, '0);
        rd(8'h20, {1'b1, DATA_ZERO});
        gap(1);
        $display("reset values done");
        r1 = $urandom();
        r2 = $urandom();
        apb(1'b1, ADDR_SERIAL_BUFFER, r1);
        apb(1'b1, ADDR_GENERAL_REG, r2);
        apb(1'b1, ADDR_STACK_POINTER, r2);
        apb(1'b1, ADDR_PORT_LATCH, r1);
        rd(ADDR_SERIAL_BUFFER, {25'h0, r1[7:0]});
        rd(ADDR_STACK_POINTER, {25'h0, r2[7:0]});
        gap(1);
        chk("port_latch", r1, port_latch);
        $display("registers done");
        apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_0001);
        apb(1'b1, ADDR_GENERAL_REG, ~r2);
        gap(1);
        chk("core_clk_en", 32'h0, {31'h0, core_clk_en});
        irq_req <= 1'b1;
        @(posedge clock);
        irq_req <= 1'b0;
        @(posedge clock);
        chk("core_clk_en", 32'h1, {31'h0, core_clk_en});
        rd(ADDR_POWER_CONTROL, '0);
        rd(ADDR_GENERAL_REG, {25'h0, r2[7:0]});
        gap(1);
        $display("idle done");
        apb(1'b1, ADDR_POWER_CONTROL, 32'h0000_0003);
        gap(1);
        irq_req <= 1'b1;
        repeat (3) @(posedge clock);
        irq_req <= 1'b0;
        chk("osc_run", 32'h0, {31'h0, osc_run});
        rd(ADDR_GENERAL_REG, {25'h0, r2[7:0]});
        rd(ADDR_STATUS, {1'b0, 32'h0000_0002});
        gap(1);
        pulse(8'h05);
        chk("short reset", 32'h0, {31'h0, seen});
        chk("osc_run", 32'h0, {31'h0, osc_run});
        pulse(8'h10);
        chk("long reset", 32'h1, {31'h0, seen});
        chk("port_latch", PORT_RESET, port_latch);
        rd(ADDR_SERIAL_BUFFER, {25'h0, r1[7:0]});
        rd(ADDR_GENERAL_REG, '0);
        rd(ADDR_POWER_CONTROL, '0);
        rd(ADDR_STACK_POINTER, {25'h0, STACK_RESET});
        rd(ADDR_STATUS, {1'b0, 32'h0000_0018});
        gap(1);
        $display("power-down done");
        conclude();
    end
endmodule : test_reset_and_power_down_control
`default_nettype wire

// ---- verilog/machine_cycle_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module machine_cycle_timer
    import rpd_pkg::*;
#(
    parameter int CLOCKS = MC_CLOCKS
) (
    input wire logic clock, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic enable, // Count only while the oscillator runs.
    input wire logic clear, // Restart the machine cycle from zero.
    output logic tick // One-cycle pulse at the end of each machine cycle.
);

    localparam logic [3:0] LAST = 4'(CLOCKS - 1);

    mc_state_t s_r;
    mc_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (clear || !enable) begin
            s_nxt.count = 4'h0;
        end else if (s_r.count == LAST) begin
            s_nxt.count = 4'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.count = s_r.count + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule : machine_cycle_timer
`default_nettype wire

// ---- verilog/reset_and_power_down_control.sv ----
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module reset_and_power_down_control
    import rpd_pkg::*;
#(
    parameter int MACHINE_CLOCKS = MC_CLOCKS
) (
    input wire logic clock, // 20 MHz oscillator clock.
    input wire logic rstn, // Power-on reset, asynchronous, active low.
    input wire logic reset_pin, // External reset pin, active high, asynchronous.
    input wire logic irq_req, // Pending interrupt from the core, same clock.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for an unmapped address.
    output logic osc_run, // Oscillator enable, low in power-down.
    output logic core_clk_en, // Core clock enable, low in idle, power-down, reset.
    output logic core_reset, // Internal reset to the core, active high.
    output logic [31:0] port_latch, // Four 8-bit port latches.
    output logic [7:0] stack_pointer // Current stack pointer value.
);

    rpd_state_t s_r;
    rpd_state_t s_nxt;
    logic mc_tick;
    logic pin_high;
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd_value;

    machine_cycle_timer #(
        .CLOCKS(MACHINE_CLOCKS)
    ) u_timer (
        .clock(clock),
        .rstn(rstn),
        .enable(s_r.osc_run),
        .clear(!pin_high),
        .tick(mc_tick)
    );

    assign pin_high = s_r.sync2;

    always_comb begin
        hit = 1'b1;
        rd_value = DATA_ZERO;
        case (paddr)
            ADDR_POWER_CONTROL: rd_value[7:0] = s_r.power_control_reg;
            ADDR_STACK_POINTER: rd_value[7:0] = s_r.stack_pointer_reg;
            ADDR_SERIAL_BUFFER: rd_value[7:0] = s_r.serial_buffer_reg;
            ADDR_PORT_LATCH: rd_value = s_r.port_latch;
            ADDR_GENERAL_REG: rd_value[7:0] = s_r.general_reg;
            ADDR_STATUS: begin
                rd_value[STAT_MODE_LSB +: 2] = s_r.mode;
                rd_value[STAT_RESET_BIT] = s_r.core_reset;
                rd_value[STAT_OSC_BIT] = s_r.osc_run;
                rd_value[STAT_CORE_CLK_BIT] = s_r.core_clk_en;
            end
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = reset_pin;
        s_nxt.sync2 = s_r.sync1;

        setup = psel && !penable;
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !hit;
        s_nxt.prdata = (setup && !pwrite && hit) ? rd_value : DATA_ZERO;
        // APB writes change registers only while the core runs; idle, power-down and reset ignore them.
        wr = psel && penable && pwrite && s_r.pready && !s_r.pslverr
            && (s_r.mode == MODE_RUN);

        // Reset recognition counts machine cycles only while the pin stays high.
        if (!pin_high) begin
            s_nxt.mc_count = MC_ZERO;
            if (s_r.core_reset) begin
                s_nxt.core_reset = 1'b0;
                s_nxt.mode = MODE_RUN;
                s_nxt.core_clk_en = 1'b1;
            end
        end else begin
            s_nxt.osc_run = 1'b1;
            if (mc_tick && s_r.mc_count != RESET_MC) begin
                s_nxt.mc_count = s_r.mc_count + MC_ONE;
            end
        end

        if (pin_high && s_r.mc_count == RESET_MC) begin
            s_nxt.core_reset = 1'b1;
            s_nxt.mode = MODE_RESET;
            s_nxt.core_clk_en = 1'b0;
            s_nxt.osc_run = 1'b1;
            s_nxt.port_latch = PORT_RESET;
            s_nxt.stack_pointer_reg = STACK_RESET;
            s_nxt.power_control_reg = REG_CLEAR;
            s_nxt.general_reg = REG_CLEAR;
        end else begin
            case (s_r.mode)
                MODE_RUN: begin
                    if (wr) begin
                        case (paddr)
                            ADDR_STACK_POINTER: s_nxt.stack_pointer_reg = pwdata[7:0];
                            ADDR_SERIAL_BUFFER: s_nxt.serial_buffer_reg = pwdata[7:0];
                            ADDR_PORT_LATCH: s_nxt.port_latch = pwdata;
                            ADDR_GENERAL_REG: s_nxt.general_reg = pwdata[7:0];
                            ADDR_POWER_CONTROL: begin
                                s_nxt.power_control_reg = pwdata[7:0];
                                if (pwdata[POWER_DOWN_BIT]) begin
                                    s_nxt.mode = MODE_POWER_DOWN;
                                    s_nxt.osc_run = 1'b0;
                                    s_nxt.core_clk_en = 1'b0;
                                end else if (pwdata[IDLE_BIT]) begin
                                    s_nxt.mode = MODE_IDLE;
                                    s_nxt.core_clk_en = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                MODE_IDLE: begin
                    if (irq_req) begin
                        s_nxt.mode = MODE_RUN;
                        s_nxt.core_clk_en = 1'b1;
                        s_nxt.power_control_reg[IDLE_BIT] = 1'b0;
                    end
                end
                MODE_POWER_DOWN: begin
                    // Interrupts are ignored; only the reset path above leaves here.
                    s_nxt.core_clk_en = 1'b0;
                    // A pin pulse too short for a reset lets the oscillator stop again.
                    if (!pin_high) begin
                        s_nxt.osc_run = 1'b0;
                    end
                end
                MODE_RESET: begin
                    // The pin branch above releases the core once the pin falls.
                end
                default: s_nxt.mode = MODE_RUN;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.mode <= MODE_RUN;
            s_r.osc_run <= 1'b1;
            s_r.core_clk_en <= 1'b1;
            s_r.stack_pointer_reg <= STACK_RESET;
            s_r.port_latch <= PORT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign osc_run = s_r.osc_run;
    assign core_clk_en = s_r.core_clk_en;
    assign core_reset = s_r.core_reset;
    assign port_latch = s_r.port_latch;
    assign stack_pointer = s_r.stack_pointer_reg;

endmodule : reset_and_power_down_control
`default_nettype wire
